// [rtl/phy_basic_control_register.sv]
// phy basic control register with strap overrides and soft reset
`timescale 1ns/1ps
`include "phy_ctl_consts.svh"

// Functional notes
// - reset bit write one resets phy
// - reset bit self clears within 500 ms
// - wrap bit loops transmit back to receive
// - line outputs quiet during loopback
// - wrap strap low forces loopback on
// - speed bit one 100, zero 10
// - speed from negotiation, strap, or bit
// - speed bit reads effective speed
// - manual mode uses duplex and speed bits, or the rate and duplex straps when negotiation strap low
// - negotiation starts on link fail or restart
// - negotiation strap low forces enable zero
// - low power bit and strap power down
// - node isolation ignores tx, floats outputs
// - repeater isolation floats receive outputs only
// - detach strap high disables isolation
// - restart bit self clears at burst start
// - duplex bit selects, reads effective duplex
// - duplex from negotiation, strap, or bit
// - collision test asserts collision on tx enable, in loopback only
// - reserved bits read zero
// - sixteen bit register at five bit address
module phy_basic_control_register
	import phy_ctl_pkg::*;
#(
	parameter int unsigned SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// management register port
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic        mgmt_write,
	input  wire logic        mgmt_read,
	input  wire logic [15:0] mgmt_wdata,
	output logic [15:0]      mgmt_rdata,
	output logic             mgmt_rvalid,
	// strap pins
	input  wire logic        wrap_strap_pin_n,
	input  wire logic        rate_strap_pin,
	input  wire logic        negotiation_strap_pin,
	input  wire logic        duplex_strap_pin,
	input  wire logic        low_power_strap_pin_n,
	input  wire logic        detach_strap_pin_n,
	// negotiation engine
	input  wire logic        neg_speed_100,
	input  wire logic        neg_full_duplex,
	input  wire logic        neg_link_fail,
	input  wire logic        neg_burst_started,
	output logic             neg_start,
	output logic             neg_enabled,
	// phy state
	input  wire logic        repeater_mode,
	output logic             phy_soft_reset,
	output logic             link_speed_100,
	output logic             link_full_duplex,
	output logic             manual_link_test,
	output logic             low_power,
	// mac side mii
	input  wire logic [3:0]  mii_tx_nibble,
	input  wire logic        mii_tx_enable,
	input  wire logic        mii_tx_error,
	output logic [3:0]       mii_rx_nibble,
	output logic             mii_rx_nibble_oe,
	output logic             mii_rx_valid,
	output logic             mii_rx_valid_oe,
	output logic             mii_rx_error,
	output logic             mii_rx_error_oe,
	output logic             mii_collision,
	output logic             mii_collision_oe,
	output logic             mii_tx_clock_oe,
	output logic             mii_rx_clock_oe,
	// coding and line side
	input  wire logic [3:0]  pcs_rx_nibble,
	input  wire logic        pcs_rx_valid,
	input  wire logic        pcs_rx_error,
	input  wire logic        pcs_collision,
	output logic [3:0]       line_tx_nibble,
	output logic             line_tx_enable,
	output logic             line_tx_error,
	output logic             line_drive_en
);

	localparam logic [`SOFT_RESET_CNT_W-1:0] RST_LAST = `SOFT_RESET_CNT_W'(SOFT_RESET_CYCLES - 1);

	strap_s                        strap_meta;
	strap_s                        strap;
	logic                          wrap_bit;
	logic                          speed_bit;
	logic                          neg_bit;
	logic                          lp_bit;
	logic                          iso_bit;
	logic                          restart_bit;
	logic                          duplex_bit;
	logic                          collision_check_bit_bit;
	logic                          next_wrap_bit;
	logic                          next_speed_bit;
	logic                          next_neg_bit;
	logic                          next_lp_bit;
	logic                          next_iso_bit;
	logic                          next_restart_bit;
	logic                          next_duplex_bit;
	logic                          next_collision_check_bit_bit;
	soft_rst_state_e               rst_state;
	soft_rst_state_e               next_rst_state;
	logic [`SOFT_RESET_CNT_W-1:0]  rst_cnt;
	logic [`SOFT_RESET_CNT_W-1:0]  next_rst_cnt;
	logic [15:0]                   next_rdata;
	logic                          wr_hit;
	logic                          wrap_eff;
	logic                          neg_eff;
	logic                          lp_eff;
	logic                          iso_eff;
	logic                          speed_eff;
	logic                          duplex_eff;
	logic [15:0]                   read_word;

	ctl_link_if link ();

	// =====================================================
	// strap synchronisers, straps are asynchronous pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_meta <= '{wrap_n: 1'b1, rate: 1'b1, neg: 1'b1, duplex: 1'b1, low_power_n: 1'b1, detach_n: 1'b1};
			strap      <= '{wrap_n: 1'b1, rate: 1'b1, neg: 1'b1, duplex: 1'b1, low_power_n: 1'b1, detach_n: 1'b1};
		end else begin
			strap_meta <= '{wrap_n: wrap_strap_pin_n, rate: rate_strap_pin, neg: negotiation_strap_pin,
			                duplex: duplex_strap_pin, low_power_n: low_power_strap_pin_n,
			                detach_n: detach_strap_pin_n};
			strap      <= strap_meta;
		end
	end

	// =====================================================
	// effective values
	always_comb begin
		wr_hit     = mgmt_write & (mgmt_addr == `PBC_ADDR);
		wrap_eff   = wrap_bit | ~strap.wrap_n;
		neg_eff    = neg_bit & strap.neg;
		// low power strap forces power down
		lp_eff     = lp_bit | ~strap.low_power_n;
		iso_eff    = iso_bit & ~strap.detach_n;
		if (neg_eff) begin
			speed_eff  = neg_speed_100;
			duplex_eff = neg_full_duplex;
		end else if (!strap.neg) begin
			speed_eff  = strap.rate;
			duplex_eff = strap.duplex;
		end else begin
			speed_eff  = speed_bit;
			duplex_eff = duplex_bit;
		end
		read_word                      = 16'h0000;
		read_word[`PBC_BIT_RESET]      = (rst_state == RST_BUSY);
		read_word[`PBC_BIT_WRAP]       = wrap_eff;
		read_word[`PBC_BIT_SPEED]      = speed_eff;
		read_word[`PBC_BIT_NEG_EN]     = neg_eff;
		read_word[`PBC_BIT_LOW_POWER]  = lp_eff;
		read_word[`PBC_BIT_ISOLATE]    = iso_eff;
		read_word[`PBC_BIT_RESTART]    = restart_bit & neg_eff;
		read_word[`PBC_BIT_DUPLEX]     = duplex_eff;
		read_word[`PBC_BIT_COLLISION_CHECK_BIT]    = collision_check_bit_bit;
		next_rdata = mgmt_read ? ((mgmt_addr == `PBC_ADDR) ? read_word : 16'h0000) : mgmt_rdata;
	end

	// =====================================================
	// stored control bits
	always_comb begin
		next_wrap_bit    = wrap_bit;
		next_speed_bit   = speed_bit;
		next_neg_bit     = neg_bit;
		next_lp_bit      = lp_bit;
		next_iso_bit     = iso_bit;
		next_duplex_bit  = duplex_bit;
		next_collision_check_bit_bit = collision_check_bit_bit;
		next_restart_bit = restart_bit;
		// restart clears at burst start, but a new write still wins
		if (neg_burst_started || !neg_eff) begin
			next_restart_bit = 1'b0;
		end
		if (wr_hit) begin
			// writes of zero refused under wrap strap
			next_wrap_bit    = mgmt_wdata[`PBC_BIT_WRAP] | ~strap.wrap_n;
			// speed bit stored for manual mode
			next_speed_bit   = mgmt_wdata[`PBC_BIT_SPEED];
			// writes of one refused under strap
			next_neg_bit     = mgmt_wdata[`PBC_BIT_NEG_EN] & strap.neg;
			// writes of zero refused under strap
			next_lp_bit      = mgmt_wdata[`PBC_BIT_LOW_POWER] | ~strap.low_power_n;
			// writes of one refused under strap
			next_iso_bit     = mgmt_wdata[`PBC_BIT_ISOLATE] & ~strap.detach_n;
			next_duplex_bit  = mgmt_wdata[`PBC_BIT_DUPLEX];
			next_collision_check_bit_bit = mgmt_wdata[`PBC_BIT_COLLISION_CHECK_BIT];
			if (mgmt_wdata[`PBC_BIT_RESTART] && mgmt_wdata[`PBC_BIT_NEG_EN] && strap.neg) begin
				next_restart_bit = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrap_bit    <= `PBC_RST_WRAP;
			speed_bit   <= `PBC_RST_SPEED;
			neg_bit     <= `PBC_RST_NEG_EN;
			lp_bit      <= `PBC_RST_LOW_POWER;
			iso_bit     <= `PBC_RST_ISOLATE;
			restart_bit <= `PBC_RST_RESTART;
			duplex_bit  <= `PBC_RST_DUPLEX;
			collision_check_bit_bit <= `PBC_RST_COLLISION_CHECK_BIT;
		end else begin
			wrap_bit    <= next_wrap_bit;
			speed_bit   <= next_speed_bit;
			neg_bit     <= next_neg_bit;
			lp_bit      <= next_lp_bit;
			iso_bit     <= next_iso_bit;
			restart_bit <= next_restart_bit;
			duplex_bit  <= next_duplex_bit;
			collision_check_bit_bit <= next_collision_check_bit_bit;
		end
	end

	// =====================================================
	// soft reset sequencer, control bits are not touched by it
	always_comb begin
		next_rst_state = rst_state;
		next_rst_cnt   = rst_cnt;
		case (rst_state)
			RST_IDLE: begin
				// write one starts reset, zero ignored
				if (wr_hit && mgmt_wdata[`PBC_BIT_RESET]) begin
					next_rst_state = RST_BUSY;
					next_rst_cnt   = '0;
				end
			end
			RST_BUSY: begin
				if (rst_cnt == RST_LAST) begin
					next_rst_state = RST_IDLE;
				end else begin
					next_rst_cnt = rst_cnt + 1'b1;
				end
			end
			default: begin
				next_rst_state = RST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_state   <= RST_IDLE;
			rst_cnt     <= '0;
			mgmt_rdata  <= 16'h0000;
			mgmt_rvalid <= 1'b0;
		end else begin
			rst_state   <= next_rst_state;
			rst_cnt     <= next_rst_cnt;
			mgmt_rdata  <= next_rdata;
			mgmt_rvalid <= mgmt_read;
		end
	end

	// =====================================================
	// outputs to the rest of the phy
	always_comb begin
		phy_soft_reset   = (rst_state == RST_BUSY);
		neg_enabled      = neg_eff;
		// start on link fail or restart
		neg_start        = neg_eff & (neg_link_fail | (restart_bit & ~neg_burst_started));
		manual_link_test = ~neg_eff;
		link_speed_100   = speed_eff;
		link_full_duplex = duplex_eff;
		low_power        = lp_eff;
		link.loopback    = wrap_eff;
		link.isolate     = iso_eff;
		link.repeater    = repeater_mode;
		link.col_test    = collision_check_bit_bit;
	end

	mii_gate u_gate (
		.clk              (clk),
		.rst              (rst),
		.ctl              (link),
		.mii_tx_nibble    (mii_tx_nibble),
		.mii_tx_enable    (mii_tx_enable),
		.mii_tx_error     (mii_tx_error),
		.mii_rx_nibble    (mii_rx_nibble),
		.mii_rx_nibble_oe (mii_rx_nibble_oe),
		.mii_rx_valid     (mii_rx_valid),
		.mii_rx_valid_oe  (mii_rx_valid_oe),
		.mii_rx_error     (mii_rx_error),
		.mii_rx_error_oe  (mii_rx_error_oe),
		.mii_collision    (mii_collision),
		.mii_collision_oe (mii_collision_oe),
		.mii_tx_clock_oe  (mii_tx_clock_oe),
		.mii_rx_clock_oe  (mii_rx_clock_oe),
		.pcs_rx_nibble    (pcs_rx_nibble),
		.pcs_rx_valid     (pcs_rx_valid),
		.pcs_rx_error     (pcs_rx_error),
		.pcs_collision    (pcs_collision),
		.line_tx_nibble   (line_tx_nibble),
		.line_tx_enable   (line_tx_enable),
		.line_tx_error    (line_tx_error),
		.line_drive_en    (line_drive_en)
	);

	// =====================================================
	// checks
	a_reset_starts: assert property (@(posedge clk) disable iff (rst)
		(rst_state == RST_IDLE && wr_hit && mgmt_wdata[`PBC_BIT_RESET]) |=> phy_soft_reset)
		else $error("reset write did not start soft reset");
	a_reset_zero_noop: assert property (@(posedge clk) disable iff (rst)
		(rst_state == RST_IDLE && !(wr_hit && mgmt_wdata[`PBC_BIT_RESET])) |=> !phy_soft_reset)
		else $error("soft reset began without a write of one");
	a_reset_bounded: assert property (@(posedge clk) disable iff (rst)
		(rst_state == RST_BUSY && rst_cnt == RST_LAST) |=> !phy_soft_reset)
		else $error("soft reset did not clear at its limit");
	a_wrap_forced: assert property (@(posedge clk) disable iff (rst)
		(!strap.wrap_n && mgmt_read && mgmt_addr == `PBC_ADDR) |=> mgmt_rdata[`PBC_BIT_WRAP])
		else $error("wrap strap did not force loopback readback");
	a_line_quiet: assert property (@(posedge clk) disable iff (rst)
		wrap_eff |=> (!line_drive_en && !line_tx_enable))
		else $error("line driven during loopback");
	a_col_test: assert property (@(posedge clk) disable iff (rst)
		(wrap_eff && collision_check_bit_bit && mii_tx_enable && !(iso_eff && !repeater_mode)) |=> mii_collision)
		else $error("collision test did not raise collision");
	a_neg_refused: assert property (@(posedge clk) disable iff (rst)
		(!strap.neg && mgmt_read && mgmt_addr == `PBC_ADDR) |=> !mgmt_rdata[`PBC_BIT_NEG_EN])
		else $error("negotiation enable read one under strap");
	a_speed_manual: assert property (@(posedge clk) disable iff (rst)
		(strap.neg && !neg_bit) |-> (link_speed_100 == speed_bit && link_full_duplex == duplex_bit))
		else $error("manual speed or duplex not from the bits");
	a_restart_zero: assert property (@(posedge clk) disable iff (rst)
		(!neg_eff && mgmt_read && mgmt_addr == `PBC_ADDR) |=> !mgmt_rdata[`PBC_BIT_RESTART])
		else $error("restart read one while negotiation off");
	a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		mgmt_rvalid |-> (mgmt_rdata[`PBC_RESERVED_HI:0] == 7'h00))
		else $error("reserved bits read nonzero");
	a_lp_forced: assert property (@(posedge clk) disable iff (rst)
		!strap.low_power_n |-> low_power)
		else $error("low power strap did not power down");

	c_reset_done: cover property (@(posedge clk) disable iff (rst) $fell(phy_soft_reset));
	c_col_test: cover property (@(posedge clk) disable iff (rst) mii_collision && wrap_eff);
	c_restart: cover property (@(posedge clk) disable iff (rst) restart_bit ##[1:20] neg_burst_started);

endmodule

// [rtl/phy_ctl_consts.svh]
// constants for the phy basic control register block
`ifndef PHY_CTL_CONSTS_SVH
`define PHY_CTL_CONSTS_SVH

// =====================================================
// register address and field positions
`define PBC_ADDR           5'h00
`define PBC_BIT_RESET      15
`define PBC_BIT_WRAP       14
`define PBC_BIT_SPEED      13
`define PBC_BIT_NEG_EN     12
`define PBC_BIT_LOW_POWER  11
`define PBC_BIT_ISOLATE    10
`define PBC_BIT_RESTART    9
`define PBC_BIT_DUPLEX     8
`define PBC_BIT_COLLISION_CHECK_BIT    7
`define PBC_RESERVED_HI    6

// =====================================================
// reset values of the stored bits
`define PBC_RST_WRAP       1'b0
`define PBC_RST_SPEED      1'b1
`define PBC_RST_NEG_EN     1'b1
`define PBC_RST_LOW_POWER  1'b0
`define PBC_RST_ISOLATE    1'b1
`define PBC_RST_RESTART    1'b0
`define PBC_RST_DUPLEX     1'b1
`define PBC_RST_COLLISION_CHECK_BIT    1'b0

// =====================================================
// timing
`define CLK_MHZ            100
`define SOFT_RESET_MS      500
`define SOFT_RESET_CYCLES  (`SOFT_RESET_MS * 1000 * `CLK_MHZ)
`define SOFT_RESET_CNT_W   26

`endif

// [rtl/phy_ctl_pkg.sv]
// types for the phy basic control register block
package phy_ctl_pkg;

	// =====================================================
	// soft reset sequencer
	typedef enum logic {
		RST_IDLE,
		RST_BUSY
	} soft_rst_state_e;

	// =====================================================
	// synchronised strap levels
	typedef struct packed {
		logic wrap_n;
		logic rate;
		logic neg;
		logic duplex;
		logic low_power_n;
		logic detach_n;
	} strap_s;

endpackage

// [rtl/ctl_link_if.sv]
// control levels from the register to the mii gating logic
`timescale 1ns/1ps
interface ctl_link_if;
	logic loopback;
	logic isolate;
	logic repeater;
	logic col_test;

	modport ctl  (output loopback, output isolate, output repeater, output col_test);
	modport gate (input  loopback, input  isolate, input  repeater, input  col_test);
endinterface

// [rtl/mii_gate.sv]
// mii loopback, isolation and collision test gating
`timescale 1ns/1ps
module mii_gate
	import phy_ctl_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	ctl_link_if.gate        ctl,
	// mac transmit side
	input  wire logic [3:0] mii_tx_nibble,
	input  wire logic       mii_tx_enable,
	input  wire logic       mii_tx_error,
	// mac receive side
	output logic [3:0]      mii_rx_nibble,
	output logic            mii_rx_nibble_oe,
	output logic            mii_rx_valid,
	output logic            mii_rx_valid_oe,
	output logic            mii_rx_error,
	output logic            mii_rx_error_oe,
	output logic            mii_collision,
	output logic            mii_collision_oe,
	output logic            mii_tx_clock_oe,
	output logic            mii_rx_clock_oe,
	// coding and line side
	input  wire logic [3:0] pcs_rx_nibble,
	input  wire logic       pcs_rx_valid,
	input  wire logic       pcs_rx_error,
	input  wire logic       pcs_collision,
	output logic [3:0]      line_tx_nibble,
	output logic            line_tx_enable,
	output logic            line_tx_error,
	output logic            line_drive_en
);

	logic       node_iso;
	logic       rx_iso;
	logic [3:0] tx_nib;
	logic       tx_en;
	logic       tx_er;
	logic [3:0] next_rx_nib;
	logic       next_rx_dv;
	logic       next_rx_er;
	logic       next_col;
	logic [3:0] next_line_nib;
	logic       next_line_en;
	logic       next_line_er;

	// =====================================================
	// next values
	always_comb begin
		node_iso = ctl.isolate & ~ctl.repeater;
		rx_iso   = ctl.isolate;
		tx_nib   = node_iso ? 4'h0 : mii_tx_nibble;
		tx_en    = node_iso ? 1'b0 : mii_tx_enable;
		tx_er    = node_iso ? 1'b0 : mii_tx_error;
		next_rx_nib = ctl.loopback ? tx_nib : pcs_rx_nibble;
		next_rx_dv  = ctl.loopback ? tx_en  : pcs_rx_valid;
		next_rx_er  = ctl.loopback ? tx_er  : pcs_rx_error;
		// collision follows tx enable in test
		next_col    = (ctl.loopback & ctl.col_test) ? tx_en : (ctl.loopback ? 1'b0 : pcs_collision);
		next_line_nib = ctl.loopback ? 4'h0 : tx_nib;
		next_line_en  = ctl.loopback ? 1'b0 : tx_en;
		next_line_er  = ctl.loopback ? 1'b0 : tx_er;
	end

	// =====================================================
	// registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mii_rx_nibble    <= 4'h0;
			mii_rx_valid     <= 1'b0;
			mii_rx_error     <= 1'b0;
			mii_collision    <= 1'b0;
			mii_rx_nibble_oe <= 1'b0;
			mii_rx_valid_oe  <= 1'b0;
			mii_rx_error_oe  <= 1'b0;
			mii_collision_oe <= 1'b0;
			mii_tx_clock_oe  <= 1'b0;
			mii_rx_clock_oe  <= 1'b0;
			line_tx_nibble   <= 4'h0;
			line_tx_enable   <= 1'b0;
			line_tx_error    <= 1'b0;
			line_drive_en    <= 1'b0;
		end else begin
			mii_rx_nibble    <= next_rx_nib;
			mii_rx_valid     <= next_rx_dv;
			mii_rx_error     <= next_rx_er;
			mii_collision    <= next_col;
			mii_rx_nibble_oe <= ~rx_iso;
			mii_rx_valid_oe  <= ~rx_iso;
			mii_rx_error_oe  <= ~rx_iso;
			mii_rx_clock_oe  <= ~rx_iso;
			mii_collision_oe <= ~node_iso;
			mii_tx_clock_oe  <= ~node_iso;
			line_tx_nibble   <= next_line_nib;
			line_tx_enable   <= next_line_en;
			line_tx_error    <= next_line_er;
			line_drive_en    <= ~ctl.loopback;
		end
	end

	// =====================================================
	// checks
	a_node_iso_float: assert property (@(posedge clk) disable iff (rst)
		node_iso |=> (!mii_collision_oe && !mii_tx_clock_oe && !mii_rx_valid_oe))
		else $error("node isolation left an mii output driven");
	a_rep_iso_keep: assert property (@(posedge clk) disable iff (rst)
		(ctl.isolate && ctl.repeater) |=> (mii_collision_oe && mii_tx_clock_oe && !mii_rx_nibble_oe))
		else $error("repeater isolation floated the wrong outputs");
	a_loop_wraps: assert property (@(posedge clk) disable iff (rst)
		(ctl.loopback && !node_iso) |=> (mii_rx_valid == $past(mii_tx_enable) && !line_tx_enable))
		else $error("loopback did not wrap transmit enable");

endmodule

// [tb/neg_engine_model.sv]
// slow negotiation engine model answering restart requests
`timescale 1ns/1ps
module neg_engine_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// negotiation handshake
	input  wire logic neg_start,
	output logic      neg_burst_started
);
	logic [2:0] cnt;
	// =====================================================
	// burst start
	// slow on purpose so the restart bit can be read as set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			neg_burst_started <= 1'b0;
		end else if (neg_start && !neg_burst_started) begin
			cnt <= cnt + 3'h1;
			neg_burst_started <= (cnt == 3'h7);
		end else begin
			cnt <= 3'h0;
			neg_burst_started <= 1'b0;
		end
	end
endmodule

// [tb/testbench.sv]
// self-checking bench for the phy basic control register
`timescale 1ns/1ps
`include "phy_ctl_consts.svh"
module testbench;
	logic clk = 1'b0, rst = 1'b1, mgmt_write = 1'b0, mgmt_read = 1'b0, mgmt_rvalid;
	logic [4:0] mgmt_addr = 5'h00;
	logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata, rd;
	logic wrap_strap_pin_n = 1'b1, rate_strap_pin = 1'b1, negotiation_strap_pin = 1'b1;
	logic duplex_strap_pin = 1'b1, low_power_strap_pin_n = 1'b1, detach_strap_pin_n = 1'b0;
	logic neg_speed_100 = 1'b1, neg_full_duplex = 1'b1, neg_burst_started, neg_start, neg_enabled;
	logic repeater_mode = 1'b0, phy_soft_reset, link_speed_100, link_full_duplex, manual_link_test, low_power;
	logic [3:0] mii_tx_nibble = 4'h0, mii_rx_nibble, line_tx_nibble;
	logic mii_tx_enable = 1'b0, mii_tx_error = 1'b0, mii_rx_nibble_oe, mii_rx_valid, mii_rx_valid_oe;
	logic mii_rx_error, mii_rx_error_oe, mii_collision, mii_collision_oe, mii_tx_clock_oe, mii_rx_clock_oe;
	logic line_tx_enable, line_tx_error, line_drive_en;
	logic neg_link_fail = 1'b0, pcs_collision = 1'b0;
	int miscompares = 0;
	int compares = 0;
	// =====================================================
	// design and partner
	phy_basic_control_register #(.SOFT_RESET_CYCLES(8)) dut (.clk, .rst, .mgmt_addr, .mgmt_write,
		.mgmt_read, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .wrap_strap_pin_n, .rate_strap_pin,
		.negotiation_strap_pin, .duplex_strap_pin, .low_power_strap_pin_n, .detach_strap_pin_n,
		.neg_speed_100, .neg_full_duplex, .neg_link_fail, .neg_burst_started, .neg_start,
		.neg_enabled, .repeater_mode, .phy_soft_reset, .link_speed_100, .link_full_duplex,
		.manual_link_test, .low_power, .mii_tx_nibble, .mii_tx_enable, .mii_tx_error, .mii_rx_nibble,
		.mii_rx_nibble_oe, .mii_rx_valid, .mii_rx_valid_oe, .mii_rx_error, .mii_rx_error_oe,
		.mii_collision, .mii_collision_oe, .mii_tx_clock_oe, .mii_rx_clock_oe,
		.pcs_rx_nibble(4'h0), .pcs_rx_valid(1'b0), .pcs_rx_error(1'b0), .pcs_collision,
		.line_tx_nibble, .line_tx_enable, .line_tx_error, .line_drive_en);
	neg_engine_model peer (.clk, .rst, .neg_start, .neg_burst_started);
	always #5 clk = ~clk;
	// =====================================================
	// shared tasks
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] d);
		tick(1);
		mgmt_write = 1'b1;
		mgmt_addr = `PBC_ADDR;
		mgmt_wdata = d;
		tick(1);
		mgmt_write = 1'b0;
	endtask
	task automatic rdr(input logic [4:0] a);
		tick(1);
		mgmt_read = 1'b1;
		mgmt_addr = a;
		tick(1);
		mgmt_read = 1'b0;
		// answer is due in this very cycle
		if (mgmt_rvalid !== 1'b1) begin
			miscompares++;
			wrap_up();
		end
		rd = mgmt_rdata;
	endtask
	// =====================================================
	// scenarios
	task automatic t_reset;
		rdr(`PBC_ADDR);
		chk("reset word", rd, 16'h3500);
		rdr(5'h01);
		chk("other addr", rd, 16'h0000);
	endtask
	task automatic t_manual;
		wr(16'h0000);
		rdr(`PBC_ADDR);
		chk("manual word", rd, 16'h0000);
		chk("manual out", {manual_link_test, link_speed_100, link_full_duplex}, 16'h0004);
		pcs_collision = 1'b1;
		tick(2);
		chk("net collision", mii_collision, 16'h0001);
		pcs_collision = 1'b0;
		wr(16'h2100);
		rdr(`PBC_ADDR);
		chk("manual 100 full", rd, 16'h2100);
		chk("link 100 full", {link_speed_100, link_full_duplex}, 16'h0003);
	endtask
	task automatic t_wrap;
		wr(16'h4080);
		mii_tx_enable = 1'b1;
		mii_tx_error = 1'b1;
		mii_tx_nibble = 4'ha;
		tick(2);
		chk("wrap rx", {mii_rx_valid, mii_rx_error, mii_rx_nibble}, 16'h003a);
		chk("wrap line", {line_tx_enable, line_tx_error, line_drive_en, line_tx_nibble}, 16'h0000);
		chk("collision_check_bit on", mii_collision, 16'h0001);
		wr(16'h4000);
		tick(2);
		chk("collision_check_bit off", mii_collision, 16'h0000);
		mii_tx_enable = 1'b0;
		mii_tx_error = 1'b0;
	endtask
	task automatic t_straps;
		{wrap_strap_pin_n, negotiation_strap_pin, rate_strap_pin} = 3'h0;
		{low_power_strap_pin_n, detach_strap_pin_n} = 2'h1;
		tick(4);
		wr(16'h3400);
		rdr(`PBC_ADDR);
		chk("strap word", rd, 16'h4900);
		chk("strap out", {low_power, neg_enabled, link_speed_100, link_full_duplex}, 16'h0009);
		{wrap_strap_pin_n, negotiation_strap_pin, rate_strap_pin} = 3'h7;
		{low_power_strap_pin_n, detach_strap_pin_n} = 2'h2;
		tick(4);
	endtask
	task automatic t_isolate;
		wr(16'h0400);
		tick(2);
		chk("node oe", {mii_rx_nibble_oe, mii_rx_valid_oe, mii_rx_error_oe, mii_rx_clock_oe,
			mii_collision_oe, mii_tx_clock_oe}, 16'h0000);
		repeater_mode = 1'b1;
		tick(3);
		chk("rep oe", {mii_rx_nibble_oe, mii_rx_valid_oe, mii_rx_error_oe, mii_rx_clock_oe,
			mii_collision_oe, mii_tx_clock_oe}, 16'h0003);
		repeater_mode = 1'b0;
	endtask
	task automatic t_restart;
		int i;
		wr(16'h1200);
		chk("neg start", neg_start, 16'h0001);
		rdr(`PBC_ADDR);
		chk("restart set", rd, 16'h3300);
		for (i = 0; i < 20 && neg_burst_started !== 1'b1; i++) tick(1);
		if (neg_burst_started !== 1'b1) begin
			miscompares++;
			wrap_up();
		end
		tick(2);
		rdr(`PBC_ADDR);
		chk("restart clear", rd, 16'h3100);
		neg_link_fail = 1'b1;
		tick(1);
		chk("link fail start", neg_start, 16'h0001);
		neg_link_fail = 1'b0;
		wr(16'h0200);
		rdr(`PBC_ADDR);
		chk("restart no neg", rd, 16'h0000);
	endtask
	task automatic t_soft;
		int i;
		wr(16'h0800);
		chk("low power", low_power, 16'h0001);
		wr(16'h0000);
		tick(4);
		wr(16'h8000);
		chk("soft reset", phy_soft_reset, 16'h0001);
		rdr(`PBC_ADDR);
		chk("reset busy", rd, 16'h8000);
		for (i = 0; i < 12 && phy_soft_reset !== 1'b0; i++) tick(1);
		chk("reset ends", phy_soft_reset, 16'h0000);
		rdr(`PBC_ADDR);
		chk("reset done", rd, 16'h0000);
	endtask
	initial begin
		tick(10);
		rst = 1'b0;
		// strap synchronisers settle before the first read
		tick(2);
		t_reset();
		t_manual();
		t_wrap();
		t_straps();
		t_isolate();
		t_restart();
		t_soft();
		wrap_up();
	end
endmodule
